// [ffc_pkg.sv]
// Shared constants and types for the flat field correction stage
package ffc_pkg;

  // ----------------------------------------------------------------
  // Pixel format and geometry
  // ----------------------------------------------------------------
  localparam int          DATA_W     = 12;
  localparam logic [11:0] PIX_MAX    = 12'hFFF;
  localparam int          COORD_W    = 8;
  localparam logic [7:0]  COORD_LAST = 8'hFF;
  localparam int          CELL_SHIFT = 6;
  localparam logic [6:0]  CELL_SPAN  = 7'h40;
  localparam int          GRID_N     = 5;
  localparam int          NODE_N     = 25;
  localparam logic [4:0]  NODE_LAST  = 5'h18;
  localparam logic [4:0]  NODE_MID   = 5'h0C;
  localparam int          FRAC_SHIFT = 12;

  // ----------------------------------------------------------------
  // Slot storage
  // ----------------------------------------------------------------
  localparam int          SLOT_W     = 4;
  localparam logic [3:0]  SLOT_LAST  = 4'hB;
  localparam int          MEM_AW     = 9;
  localparam int          MEM_DEPTH  = 384;

  // ----------------------------------------------------------------
  // Register map
  // ----------------------------------------------------------------
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_TARGET = 8'h04;
  localparam logic [7:0]  REG_SLOT   = 8'h08;
  localparam logic [7:0]  REG_CMD    = 8'h0C;
  localparam logic [7:0]  REG_STATUS = 8'h10;
  localparam int          CTRL_FIX_BIT  = 0;
  localparam int          CTRL_MODE_BIT = 1;
  localparam int          CTRL_HOT_BIT  = 2;
  localparam int          CTRL_RESPONSE_UNIFORMITY_FIX_BIT = 3;
  localparam int          CMD_BUILD_BIT   = 0;
  localparam int          CMD_STORE_BIT   = 1;
  localparam int          CMD_RESTORE_BIT = 2;
  localparam int          STAT_BUSY_BIT = 0;
  localparam int          STAT_DONE_BIT = 1;
  localparam logic [3:0]  CTRL_RST   = 4'h0;
  localparam logic [11:0] TARGET_RST = 12'h800;
  localparam logic [11:0] TARGET_MIN = 12'h001;

  // ----------------------------------------------------------------
  // Correction tuning
  // ----------------------------------------------------------------
  localparam logic [11:0] HOT_DELTA  = 12'h200;
  localparam int          GAIN_SHIFT = 8;
  localparam logic [15:0][8:0] RESPONSE_UNIFORMITY_FIX_GAIN = '{default: 9'h100};

  // ----------------------------------------------------------------
  // Timing
  // ----------------------------------------------------------------
  localparam int          CLK_NS      = 10;
  localparam int          NV_WRITE_NS = 40;
  localparam int          NV_TICK_CYC = (NV_WRITE_NS + CLK_NS - 1) / CLK_NS;

  // ----------------------------------------------------------------
  // Types
  // ----------------------------------------------------------------
  typedef struct packed {
    logic        valid;
    logic        sof;
    logic        eol;
    logic [11:0] data;
  } ffc_pix_t;

  typedef struct packed {
    logic        wr;
    logic        rd;
    logic [7:0]  addr;
    logic [31:0] wdata;
  } ffc_bus_t;

  typedef enum logic [1:0] {
    ST_IDLE    = 2'b00,
    ST_BUILD   = 2'b01,
    ST_STORE   = 2'b10,
    ST_RESTORE = 2'b11
  } ffc_state_t;

endpackage

// [ffc_map_mem.sv]
// Non-volatile slot store for reduced flat field maps
`timescale 1ns/10ps
`default_nettype none
module ffc_map_mem
  import ffc_pkg::*;
(
  // Clock
  input  wire logic              clock_in,
  // Access
  input  wire logic              wr_en_in,
  input  wire logic [MEM_AW-1:0] addr_in,
  input  wire logic [DATA_W-1:0] wdata_in,
  output logic      [DATA_W-1:0] rdata_out
);
  logic [DATA_W-1:0] mem_reg [MEM_DEPTH];

  // Contents survive reset on purpose
  always_ff @(posedge clock_in)
  begin
    if (wr_en_in)
      mem_reg[addr_in] <= wdata_in;
    rdata_out <= mem_reg[addr_in];
  end
endmodule // ffc_map_mem
`default_nettype wire

// [ffc_tick.sv]
// Enable pulse divider pacing slot writes
`timescale 1ns/10ps
`default_nettype none
module ffc_tick
  import ffc_pkg::*;
(
  // Clock and reset
  input  wire logic clock_in,
  input  wire logic rst_b_in,
  // Control
  input  wire logic run_in,
  output logic      tick_out
);
  logic [7:0] cnt_reg;

  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in || !run_in)
    begin
      cnt_reg  <= 8'h00;
      tick_out <= 1'b0;
    end
    else if (cnt_reg == 8'(NV_TICK_CYC - 1))
    begin
      cnt_reg  <= 8'h00;
      tick_out <= 1'b1;
    end
    else
    begin
      cnt_reg  <= cnt_reg + 8'h01;
      tick_out <= 1'b0;
    end
  end
endmodule // ffc_tick
`default_nettype wire

// [ffc_top.sv]
// Flat field correction stage with map build, store and restore
//
// Local design decisions: the placing of the registers and the strobed register port.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// R1 - With correction on, output is raw level times target level divided by map level.
// R2 - Reduced map is expanded to full frame by bilinear interpolation.
// R3 - Build command captures the map from exactly the next whole frame.
// R4 - Host sets window origin zero and full size before building.
// R5 - Host free-runs or triggers so one frame really arrives.
// R6 - Correction enable off passes pixels through undivided.
// R7 - Slot selector names one of twelve slots for store and restore.
// R8 - Store copies the working map into the selected slot.
// R9 - Working map is volatile and cleared by reset.
// R10 - Restore copies the selected slot over the working map.
// R11 - Host restores before storing to discard a fresh map.
// R12 - Automatic mode picks the target level internally.
// R13 - User mode uses host target level 1 to 4095, 12-bit scale.
// R14 - Host should enable defect correction before building; the build stores raw pix_in.data, so the hot pixel fix does not reach the map.
// R15 - Hot pixel fix, when on, removes hot pixels.
// R16 - Per-block response coefficients scale each pixel.
// R17 - Result clamps to full scale; zero map means no correction.
// R18 - Map commands accepted only when idle; completion is reported.
module ffc_top
  import ffc_pkg::*;
(
  // Clock and reset
  input  wire logic          clock_in,
  input  wire logic          rst_b_in,
  // Register port
  input  wire ffc_pkg::ffc_bus_t bus_in,
  output logic        [31:0] rd_data_out,
  // Pixel stream
  input  wire ffc_pkg::ffc_pix_t pix_in,
  output var ffc_pkg::ffc_pix_t  pix_out
);
  import ffc_pkg::*;

  // ----------------------------------------------------------------
  // Registers and state
  // ----------------------------------------------------------------
  logic [3:0]        ctrl_reg;
  logic [11:0]       target_reg;
  logic [SLOT_W-1:0] slot_reg;
  logic              done_reg;
  ffc_state_t        state_reg;
  logic [11:0]       map_reg [NODE_N];
  logic [4:0]        idx_reg;
  logic              ld_pend_reg;
  logic [4:0]        ld_idx_reg;
  logic              armed_reg;
  logic [7:0]        x_reg;
  logic [7:0]        y_reg;
  logic [11:0]       prev_reg;
  ffc_pix_t          s1_reg;
  logic [11:0]       s1_map_reg;
  logic [11:0]       s1_tgt_reg;
  logic              tick;
  logic [11:0]       mem_rdata;
  logic              op_end;

  wire logic wr_hit_cmd = bus_in.wr && bus_in.addr == REG_CMD;
  wire logic idle       = state_reg == ST_IDLE;
  wire logic cmd_ok     = wr_hit_cmd && idle;

  function automatic logic [23:0] lerp(input logic [17:0] a,
                                       input logic [17:0] b,
                                       input logic [6:0]  f);
    lerp = 24'(a * (CELL_SPAN - f)) + 24'(b * f);
  endfunction

  // ----------------------------------------------------------------
  // Register port
  // ----------------------------------------------------------------
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      ctrl_reg   <= CTRL_RST;
      target_reg <= TARGET_RST;
      slot_reg   <= '0;
    end
    else if (bus_in.wr)
    begin
      if (bus_in.addr == REG_CTRL)
        ctrl_reg <= bus_in.wdata[3:0];
      if (bus_in.addr == REG_TARGET)  // [R13]
        target_reg <= (bus_in.wdata[11:0] == 12'h000) ? TARGET_MIN
                                                      : bus_in.wdata[11:0];
      // Out-of-range slot numbers are dropped, old slot kept
      if (bus_in.addr == REG_SLOT && bus_in.wdata[3:0] <= SLOT_LAST)
        slot_reg <= bus_in.wdata[3:0];  // [R7]
    end
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
      rd_data_out <= 32'h0000_0000;
    else if (bus_in.rd)
      case (bus_in.addr)
        REG_CTRL:   rd_data_out <= {28'h0000000, ctrl_reg};
        REG_TARGET: rd_data_out <= {20'h00000, target_reg};
        REG_SLOT:   rd_data_out <= {28'h0000000, slot_reg};
        REG_STATUS: rd_data_out <= {30'h0, done_reg, !idle};
        default:    rd_data_out <= 32'h0000_0000;
      endcase
    else
      rd_data_out <= 32'h0000_0000;
  end

  // Set wins over a same-cycle clear
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
      done_reg <= 1'b0;
    else if (op_end)
      done_reg <= 1'b1;  // [R18]
    else if (bus_in.wr && bus_in.addr == REG_STATUS &&
             bus_in.wdata[STAT_DONE_BIT])
      done_reg <= 1'b0;
  end

  // ----------------------------------------------------------------
  // Pixel position
  // ----------------------------------------------------------------
  wire logic [7:0] cur_x = pix_in.sof ? 8'h00 : x_reg;
  wire logic [7:0] cur_y = pix_in.sof ? 8'h00 : y_reg;

  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      x_reg <= 8'h00;
      y_reg <= 8'h00;
    end
    else if (pix_in.valid)
    begin
      x_reg <= pix_in.eol ? 8'h00 : cur_x + 8'h01;
      y_reg <= pix_in.eol ? cur_y + 8'h01 : cur_y;
    end
  end

  // ----------------------------------------------------------------
  // Map operations
  // ----------------------------------------------------------------
  wire logic frame_end = pix_in.valid && pix_in.eol &&
                         cur_y == COORD_LAST;
  wire logic in_build  = state_reg == ST_BUILD &&
                         pix_in.valid && (pix_in.sof || armed_reg);
  wire logic col_node  = cur_x[5:0] == 6'h00 || cur_x == COORD_LAST;
  wire logic row_node  = cur_y[5:0] == 6'h00 || cur_y == COORD_LAST;
  wire logic [2:0] gcol = cur_x == COORD_LAST ? 3'h4 : {1'b0, cur_x[7:6]};
  wire logic [2:0] grow = cur_y == COORD_LAST ? 3'h4 : {1'b0, cur_y[7:6]};
  wire logic [4:0] gidx = 5'(grow * GRID_N) + 5'(gcol);

  assign op_end = (in_build && frame_end) ||
                  (state_reg == ST_STORE && tick && idx_reg == NODE_LAST) ||
                  (ld_pend_reg && ld_idx_reg == NODE_LAST);

  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
      state_reg <= ST_IDLE;
    else
      case (state_reg)
        ST_IDLE:
          if (cmd_ok && bus_in.wdata[CMD_BUILD_BIT])
            state_reg <= ST_BUILD;  // [R3]
          else if (cmd_ok && bus_in.wdata[CMD_RESTORE_BIT])
            state_reg <= ST_RESTORE;
          else if (cmd_ok && bus_in.wdata[CMD_STORE_BIT])
            state_reg <= ST_STORE;
        ST_BUILD, ST_STORE, ST_RESTORE:
          if (op_end)
            state_reg <= ST_IDLE;
        default:
          state_reg <= ST_IDLE;
      endcase
  end

  // Armed only by a fresh frame start, never mid-frame
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in || state_reg != ST_BUILD)
      armed_reg <= 1'b0;
    else if (pix_in.valid && pix_in.sof)
      armed_reg <= 1'b1;  // [R3]
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in || idle)
      idx_reg <= 5'h00;
    else if (state_reg == ST_RESTORE && idx_reg != NODE_LAST)
      idx_reg <= idx_reg + 5'h01;
    else if (state_reg == ST_STORE && tick)
      idx_reg <= idx_reg + 5'h01;
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      ld_pend_reg <= 1'b0;
      ld_idx_reg  <= 5'h00;
    end
    else
    begin
      ld_pend_reg <= state_reg == ST_RESTORE && !op_end;
      ld_idx_reg  <= idx_reg;
    end
  end

  // Volatile working map: reset leaves all zero, i.e. no correction
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
      for (int i = 0; i < NODE_N; i++)
        map_reg[i] <= 12'h000;  // [R9]
    else if (in_build && col_node && row_node)
      map_reg[gidx] <= pix_in.data;  // [R3]
    else if (ld_pend_reg)
      map_reg[ld_idx_reg] <= mem_rdata;  // [R10]
  end

  ffc_tick u_tick (
    .clock_in (clock_in),
    .rst_b_in (rst_b_in),
    .run_in   (state_reg == ST_STORE),
    .tick_out (tick)
  );

  ffc_map_mem u_mem (
    .clock_in  (clock_in),
    .wr_en_in  (state_reg == ST_STORE && tick),  // [R8]
    .addr_in   ({slot_reg, idx_reg}),  // [R7]
    .wdata_in  (map_reg[idx_reg]),
    .rdata_out (mem_rdata)
  );

  // ----------------------------------------------------------------
  // Correction pipeline
  // ----------------------------------------------------------------
  wire logic [1:0]  cx = cur_x[7:6];
  wire logic [1:0]  cy = cur_y[7:6];
  wire logic [6:0]  fx = {1'b0, cur_x[5:0]};
  wire logic [6:0]  fy = {1'b0, cur_y[5:0]};
  wire logic [4:0]  n00 = 5'(cy * GRID_N) + 5'(cx);
  wire logic [23:0] h0 = lerp(18'(map_reg[n00]), 18'(map_reg[n00 + 5'h01]),
                              fx);
  wire logic [23:0] h1 = lerp(18'(map_reg[n00 + 5'h05]),
                              18'(map_reg[n00 + 5'h06]), fx);
  wire logic [23:0] hv = lerp(h0[17:0], h1[17:0], fy);  // [R2]

  wire logic        hot = ctrl_reg[CTRL_HOT_BIT] && cur_x != 8'h00 &&
                          {1'b0, pix_in.data} > {1'b0, prev_reg} +
                          {1'b0, HOT_DELTA};
  wire logic [11:0] clean = hot ? prev_reg : pix_in.data;  // [R15]
  wire logic [20:0] scaled = clean * RESPONSE_UNIFORMITY_FIX_GAIN[{cy, cx}];
  wire logic [12:0] gained = scaled[20:GAIN_SHIFT];
  wire logic [11:0] resp = !ctrl_reg[CTRL_RESPONSE_UNIFORMITY_FIX_BIT] ? clean :
                           gained[12] ? PIX_MAX : gained[11:0];  // [R16]
  wire logic [11:0] tgt = ctrl_reg[CTRL_MODE_BIT] ? target_reg  // [R13]
                          : map_reg[NODE_MID];  // [R12]

  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
      prev_reg <= 12'h000;
    else if (pix_in.valid)
      prev_reg <= clean;
  end

  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      s1_reg     <= '0;
      s1_map_reg <= 12'h000;
      s1_tgt_reg <= 12'h000;
    end
    else
    begin
      s1_reg      <= pix_in;
      s1_reg.data <= resp;
      s1_map_reg  <= hv[FRAC_SHIFT+11:FRAC_SHIFT];
      s1_tgt_reg  <= tgt;
    end
  end

  wire logic [23:0] quot = (s1_reg.data * s1_tgt_reg) /
                           24'(s1_map_reg | {11'h000, s1_map_reg == 12'h0});
  wire logic        use_fix = ctrl_reg[CTRL_FIX_BIT] &&
                              s1_map_reg != 12'h000;  // [R17]

  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
      pix_out <= '0;
    else
    begin
      pix_out <= s1_reg;
      if (!use_fix)
        pix_out.data <= s1_reg.data;  // [R6]
      else if (quot > 24'(PIX_MAX))
        pix_out.data <= PIX_MAX;  // [R17]
      else
        pix_out.data <= quot[11:0];  // [R1]
    end
  end

  // ----------------------------------------------------------------
  // Checks
  // ----------------------------------------------------------------
  default clocking cb @(posedge clock_in); endclocking
  default disable iff (!rst_b_in);

  chk_bypass_path: // [R6]
  assert property (!ctrl_reg[CTRL_FIX_BIT] && s1_reg.valid |=>
                   pix_out.data == $past(s1_reg.data))
    else $error("Bypass did not pass pixel through");
  chk_unity_ratio: // [R1]
  assert property (use_fix && s1_map_reg == s1_tgt_reg |=>
                   pix_out.data == $past(s1_reg.data))
    else $error("Equal map and target changed pixel");
  chk_zero_map: // [R17]
  assert property (s1_map_reg == 12'h000 |=>
                   pix_out.data == $past(s1_reg.data))
    else $error("Zero map value altered pixel");
  chk_interp_node: // [R2]
  assert property (pix_in.valid && cur_x[5:0] == 6'h00 &&
                   cur_y[5:0] == 6'h00 |=> s1_map_reg == $past(map_reg[n00]))
    else $error("Interpolation wrong at grid node");
  chk_cmd_busy: // [R18]
  assert property (!idle && wr_hit_cmd |=> state_reg == $past(state_reg) ||
                   $past(op_end))
    else $error("Command taken while busy");
  chk_build_start: // [R3]
  assert property (cmd_ok && bus_in.wdata[CMD_BUILD_BIT] |=>
                   state_reg == ST_BUILD && !armed_reg)
    else $error("Build not armed for next frame");
  chk_store_time: // [R8]
  assert property (cmd_ok && bus_in.wdata[2:0] == 3'b010 |->
                   ##[100:102] done_reg)
    else $error("Store did not finish in time");
  chk_restore_time: // [R10]
  assert property (cmd_ok && bus_in.wdata[2:0] == 3'b100 |->
                   ##[25:27] done_reg)
    else $error("Restore did not finish in time");
  chk_reset_map: // [R9]
  assert property ($rose(rst_b_in) |-> map_reg[NODE_MID] == 12'h000)
    else $error("Working map not cleared by reset");
  chk_slot_range: // [R7]
  assert property (slot_reg <= SLOT_LAST)
    else $error("Slot selector out of range");
  chk_user_target: // [R13]
  assert property (ctrl_reg[CTRL_MODE_BIT] |-> tgt == target_reg &&
                   target_reg != 12'h000)
    else $error("User target not applied");

  cov_build: cover property (in_build && frame_end);
  cov_store: cover property (state_reg == ST_STORE ##1 idle);
  cov_restore: cover property (state_reg == ST_RESTORE ##1 idle);
  cov_clamp: cover property (use_fix && quot > 24'(PIX_MAX));
endmodule // ffc_top
`default_nettype wire

// [ffc_pix_src.sv]
// Sensor-side pixel stream model feeding the correction stage
`timescale 1ns/10ps
`default_nettype none
module ffc_pix_src
  import ffc_pkg::*;
(
  // Clock and reset
  input  wire logic        clock_in,
  input  wire logic        rst_b_in,
  // Frame request
  input  wire logic        go_in,
  input  wire logic [8:0]  lines_in,
  input  wire logic [11:0] base_in,
  input  wire logic [3:0]  slope_in,
  input  wire logic [7:0]  spike_col_in,
  input  wire logic [11:0] spike_val_in,
  // Stream
  output var ffc_pkg::ffc_pix_t pix_out,
  output logic             busy_out
);
  import ffc_pkg::*;

  logic [7:0] col_reg;
  logic [8:0] row_reg;

  // ----------------------------------------------------------------
  // Frame sequencing
  // ----------------------------------------------------------------
  // Always starts at column 0, row 0, full 256-pixel lines
  // One request yields exactly one frame, as a trigger would
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
    begin
      busy_out <= 1'b0;
      col_reg  <= 8'h00;
      row_reg  <= 9'h000;
    end
    else if (go_in && !busy_out)
    begin
      busy_out <= 1'b1;
      col_reg  <= 8'h00;
      row_reg  <= 9'h000;
    end
    else if (busy_out)
    begin
      col_reg <= col_reg + 8'h01;
      if (col_reg == COORD_LAST)
      begin
        row_reg <= row_reg + 9'h001;
        if (row_reg == lines_in - 9'h001)
          busy_out <= 1'b0;
      end
    end
  end

  // ----------------------------------------------------------------
  // Pixel values
  // ----------------------------------------------------------------
  // Idle data toggles so a stale value never looks valid
  always_ff @(posedge clock_in)
  begin
    if (!rst_b_in)
      pix_out <= '0;
    else if (busy_out)
    begin
      pix_out.valid <= 1'b1;
      pix_out.sof   <= (col_reg == 8'h00) && (row_reg == 9'h000);
      pix_out.eol   <= (col_reg == COORD_LAST);
      if (spike_val_in != 12'h000 && col_reg == spike_col_in)
        pix_out.data <= spike_val_in;
      else
        pix_out.data <= base_in + 12'(slope_in * col_reg);
    end
    else
    begin
      pix_out.valid <= 1'b0;
      pix_out.sof   <= 1'b0;
      pix_out.eol   <= 1'b0;
      pix_out.data  <= ~pix_out.data;
    end
  end
endmodule // ffc_pix_src
`default_nettype wire

// [tb_flat_field_correction.sv]
// Self-checking bench for the flat field correction stage
`timescale 1ns/10ps
`default_nettype none
module tb_flat_field_correction;
  import ffc_pkg::*;

  localparam int MD_OFF = 0, MD_PASS = 1, MD_CONST = 2, MD_HOT = 3;

  logic        clock_in = 1'b0;
  logic        rst_b_in = 1'b0;
  ffc_bus_t    bus      = '0;
  logic [31:0] rd_data;
  ffc_pix_t    pix, pix_out;
  logic        go = 1'b0, busy;
  logic [8:0]  lines = 9'h001;
  logic [11:0] base = 12'h000, spike_val = 12'h000, exp_val = 12'h000;
  logic [3:0]  slope = 4'h0;
  logic [7:0]  spike_col = 8'h00, col = 8'h00;
  logic [11:0] prev = 12'h000;
  logic        last_eol = 1'b0, k1 = 1'b0, k2 = 1'b0;
  ffc_pix_t    x1 = '0, x2 = '0;
  int          chk_mode = MD_OFF;
  int          err_total = 0, check_count = 0;

  always #5 clock_in = ~clock_in;

  ffc_top dut (.clock_in(clock_in), .rst_b_in(rst_b_in), .bus_in(bus),
               .rd_data_out(rd_data), .pix_in(pix), .pix_out(pix_out));

  ffc_pix_src src (.clock_in(clock_in), .rst_b_in(rst_b_in), .go_in(go),
                   .lines_in(lines), .base_in(base), .slope_in(slope),
                   .spike_col_in(spike_col), .spike_val_in(spike_val),
                   .pix_out(pix), .busy_out(busy));

  // ----------------------------------------------------------------
  // Shared tasks
  // ----------------------------------------------------------------
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    check_count++;
    if (got !== exp)
    begin
      err_total++;
      $display("ERROR %s expected %h seen %h", what, exp, got);
    end
  endtask

  task automatic reg_wr(logic [7:0] a, logic [31:0] d);
    @(posedge clock_in);
    bus <= '{wr: 1'b1, rd: 1'b0, addr: a, wdata: d};
    @(posedge clock_in);
    bus <= '0;
  endtask

  task automatic reg_rd(logic [7:0] a, logic [31:0] exp);
    @(posedge clock_in);
    bus <= '{wr: 1'b0, rd: 1'b1, addr: a, wdata: 32'h0};
    @(posedge clock_in);
    bus <= '0;
    #1;
    check($sformatf("reg %h", a), exp, rd_data);
  endtask

  task automatic wait_done();
    int n;
    for (n = 0; n < 40000; n++)
    begin
      @(posedge clock_in);
      bus <= '{wr: 1'b0, rd: 1'b1, addr: REG_STATUS, wdata: 32'h0};
      @(posedge clock_in);
      bus <= '0;
      #1;
      if (rd_data[STAT_DONE_BIT] === 1'b1)
        break;
    end
    check("done", 32'h1, {31'h0, rd_data[STAT_DONE_BIT]});
  endtask

  // Pipeline drains before the check mode is dropped
  task automatic run_frame(logic [8:0] n, logic [11:0] b, logic [3:0] s,
                           logic [11:0] sv, int md, logic [11:0] ev);
    int i;
    lines     <= n;
    base      <= b;
    slope     <= s;
    spike_col <= 8'h0A;
    spike_val <= sv;
    chk_mode = md; exp_val = ev;
    @(posedge clock_in);
    go <= 1'b1;
    @(posedge clock_in);
    go <= 1'b0;
    #1;
    for (i = 0; i < 70000 && busy; i++)
      @(posedge clock_in);
    repeat (4) @(posedge clock_in);
    chk_mode = MD_OFF;
  endtask

  task automatic results();
    $display("checks %0d mismatches %0d", check_count, err_total);
    if (err_total == 0 && check_count > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask

  // ----------------------------------------------------------------
  // Output monitor, two cycles behind the input
  // ----------------------------------------------------------------
  // Right-edge cell skipped in constant mode: its span is one short
  always @(negedge clock_in)
  begin
    if (k2 && x2.valid)
      check("pix_out", 32'(x2), 32'(pix_out));
    else if (k2)
      check("pix_out.valid", 32'h0, {31'h0, pix_out.valid});
    k2 = k1;
    x2 = x1;
    x1 = pix;
    if (pix.valid)
    begin
      col = (pix.sof || last_eol) ? 8'h00 : col + 8'h01;
      last_eol = pix.eol;
      if (chk_mode == MD_CONST)
        x1.data = exp_val;
      if (chk_mode == MD_HOT && col != 8'h00 &&
          13'(pix.data) > 13'(prev) + 13'(HOT_DELTA))
        x1.data = prev;
      prev = pix.data;
    end
    k1 = (chk_mode != MD_OFF) &&
         !(chk_mode == MD_CONST && pix.valid && col >= 8'hC0);
  end

  // ----------------------------------------------------------------
  // Watchdog
  // ----------------------------------------------------------------
  initial
  begin
    repeat (90000) @(posedge clock_in);
    err_total++;
    results();
  end

  // ----------------------------------------------------------------
  // Test sequence
  // ----------------------------------------------------------------
  initial
  begin
    repeat (8) @(posedge clock_in);
    rst_b_in <= 1'b1;
    reg_rd(REG_CTRL, {28'h0, CTRL_RST});
    reg_rd(REG_TARGET, {20'h0, TARGET_RST});
    reg_rd(REG_SLOT, 32'h0);
    reg_rd(REG_STATUS, 32'h0);
    reg_rd(REG_CMD, 32'h0);
    reg_rd(8'h14, 32'h0);
    reg_wr(REG_TARGET, 32'h0);
    reg_rd(REG_TARGET, {20'h0, TARGET_MIN});
    reg_wr(REG_SLOT, {28'h0, SLOT_LAST});
    reg_wr(REG_SLOT, 32'hC);
    reg_rd(REG_SLOT, {28'h0, SLOT_LAST});
    reg_wr(REG_CTRL, 32'h8);
    run_frame(9'h002, 12'h123, 4'h3, 12'h000, MD_PASS, 0);
    reg_wr(REG_CTRL, 32'h3);
    reg_wr(REG_TARGET, 32'h800);
    run_frame(9'h001, 12'h200, 4'h4, 12'h000, MD_PASS, 0);
    // Map ramps along x so interpolation is exact between nodes
    reg_wr(REG_CTRL, 32'h7);
    reg_wr(REG_CMD, 32'h1);
    reg_rd(REG_STATUS, 32'h1);
    run_frame(9'h100, 12'h200, 4'h4, 12'h000, MD_OFF, 0);
    wait_done();
    run_frame(9'h002, 12'h200, 4'h4, 12'h000, MD_CONST, 12'h800);
    reg_wr(REG_CTRL, 32'h1);
    run_frame(9'h001, 12'h200, 4'h4, 12'h000, MD_CONST, 12'h400);
    reg_wr(REG_CTRL, 32'h3);
    run_frame(9'h001, 12'hFFF, 4'h0, 12'h000, MD_CONST, 12'hFFF);
    reg_wr(REG_STATUS, 32'h2);
    reg_rd(REG_STATUS, 32'h0);
    // A build issued mid-store must be dropped, or busy would linger
    reg_wr(REG_CMD, 32'h2);
    reg_wr(REG_CMD, 32'h1);
    reg_rd(REG_STATUS, 32'h1);
    wait_done();
    reg_rd(REG_STATUS, 32'h2);
    @(posedge clock_in);
    rst_b_in <= 1'b0;
    repeat (8) @(posedge clock_in);
    rst_b_in <= 1'b1;
    reg_wr(REG_CTRL, 32'h3);
    run_frame(9'h001, 12'h200, 4'h4, 12'h000, MD_PASS, 0);
    reg_wr(REG_SLOT, {28'h0, SLOT_LAST});
    reg_wr(REG_CMD, 32'h4);
    wait_done();
    run_frame(9'h001, 12'h200, 4'h4, 12'h000, MD_CONST, 12'h800);
    reg_wr(REG_CTRL, 32'h4);
    run_frame(9'h001, 12'h100, 4'h0, 12'h400, MD_HOT, 0);
    results();
  end
endmodule // tb_flat_field_correction
`default_nettype wire
